// ===== core/alfo_pkg.sv
// Package for the literal and file arithmetic datapath: opcodes, fields and flag positions.
`default_nettype none
package alfo_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSN_W  = 14;
  localparam int unsigned ADDR_W  = 7;
  localparam logic [5:0] OPC_AND_LIT_VAL  = 6'h39;
  localparam logic [4:0] OPC_ADD_LIT_HI   = 5'h1f;
  localparam logic [5:0] OPC_ADD_FILE_VAL = 6'h07;
  localparam logic [5:0] OPC_AND_FILE_VAL = 6'h05;
  localparam int unsigned OPC_HI = 13;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned CARRY_POS  = 0;
  localparam int unsigned DIGIT_POS  = 1;
  localparam int unsigned ZERO_POS   = 2;
  localparam logic [6:0] STATUS_ADDR = 7'h03;
  localparam logic [6:0] TIMER_ADDR  = 7'h01;
  localparam logic [7:0] WORK_RESET  = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [7:0] LOW_NIB_MASK = 8'h0f;
  // Write-back request towards the file register space.
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } alfo_file_wr_type;
  // Operation selected by the decode.
  typedef enum logic [2:0] {OP_NONE, OP_ADDL, OP_ANDL, OP_ADDF, OP_ANDF} alfo_op_type;
endpackage : alfo_pkg
`default_nettype wire

// ===== core/alfo_adder.sv
// Eight bit adder producing sum, carry out of bit 7 and carry out of bit 3.
`timescale 1ns/1ns
`default_nettype none
module alfo_adder
  import alfo_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  output logic      [7:0] sum_o,
  output logic            carry_o,
  output logic            digit_o
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;
  // Carries come from separate widened sums so no bit is lost.
  assign full_sum = {1'b0, a_i} + {1'b0, b_i};
  assign low_sum  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
  assign sum_o    = full_sum[7:0];
  assign carry_o  = full_sum[8];
  assign digit_o  = low_sum[4];
endmodule : alfo_adder
`default_nettype wire

// ===== core/alfo_alu.sv
// Datapath for add and and instructions with literal or file register operands.
`timescale 1ns/1ns
`default_nettype none
module alfo_alu
  import alfo_pkg::*;
(
  input  wire logic                   CLK_I,
  input  wire logic                   ARST_N_I,
  input  wire logic                   INSN_VALID_I,
  input  wire logic [INSN_W-1:0]      INSN_I,
  input  wire logic [DATA_W-1:0]      FILE_RDATA_I,
  input  wire logic                   FILE_IS_PORT_I,
  input  wire logic [DATA_W-1:0]      PIN_LEVELS_I,
  input  wire logic                   PRESCALER_TO_TIMER_I,
  output logic      [ADDR_W-1:0]      FILE_ADDR_O,
  output alfo_file_wr_type            FILE_WR_O,
  output logic                        PRESCALER_CLR_O,
  output logic      [DATA_W-1:0]      WORK_O,
  output logic                        CARRY_O,
  output logic                        DIGIT_CARRY_O,
  output logic                        ZERO_O
);
  logic [DATA_W-1:0] work_ff;
  logic [DATA_W-1:0] nxt_work;
  logic [2:0]        flags_ff;
  logic [2:0]        nxt_flags;
  alfo_file_wr_type  wr_ff;
  alfo_file_wr_type  nxt_wr;
  logic              pre_clr_ff;
  logic              nxt_pre_clr;
  alfo_op_type       op;
  wire  [5:0]        opc     = INSN_I[OPC_HI:OPC_LO];
  wire  [7:0]        literal = INSN_I[7:0];
  wire               dir     = INSN_I[DIR_BIT];
  wire  [6:0]        addr    = INSN_I[6:0];
  wire  [7:0]        file_op;
  wire  [7:0]        operand;
  wire  [7:0]        sum;
  wire               sum_c;
  wire               sum_dig;
  wire  [7:0]        and_res;
  wire  [7:0]        result;
  wire               is_add;
  wire               is_file;
  wire               to_file;
  wire  [2:0]        new_flags;
  wire  [7:0]        wr_data;

  // Opcode decode; anything else leaves state untouched.
  // The add literal pattern ignores its lowest opcode bit, so two codes map to it.
  assign op = !INSN_VALID_I                       ? OP_NONE :
              (opc[5:1] == OPC_ADD_LIT_HI)        ? OP_ADDL :
              (opc == OPC_AND_LIT_VAL)            ? OP_ANDL :
              (opc == OPC_ADD_FILE_VAL)           ? OP_ADDF :
              (opc == OPC_AND_FILE_VAL)           ? OP_ANDF :
                                                    OP_NONE;
  assign is_add  = (op == OP_ADDL) || (op == OP_ADDF);
  assign is_file = (op == OP_ADDF) || (op == OP_ANDF);
  assign to_file = is_file && dir;

  // Ports are read at the pins so read-modify-write sees external levels.
  assign file_op = FILE_IS_PORT_I ? PIN_LEVELS_I : FILE_RDATA_I;
  assign operand = is_file ? file_op : literal;
  assign and_res = work_ff & operand;
  assign result  = is_add ? sum : and_res;
  assign FILE_ADDR_O = addr;

  alfo_adder u_adder (
    .a_i     (work_ff),
    .b_i     (operand),
    .sum_o   (sum),
    .carry_o (sum_c),
    .digit_o (sum_dig)
  );

  // Adds touch all three flags, ands only zero.
  assign new_flags[ZERO_POS]  = (result == '0);
  assign new_flags[CARRY_POS] = is_add ? sum_c   : flags_ff[CARRY_POS];
  assign new_flags[DIGIT_POS] = is_add ? sum_dig : flags_ff[DIGIT_POS];

  // Status writes keep the fresh flags over the data bits.
  // Without this a stale data bit would overwrite a flag that the instruction just set.
  assign wr_data = (addr == STATUS_ADDR) ?
                   {result[7:3], new_flags[ZERO_POS], new_flags[DIGIT_POS],
                    new_flags[CARRY_POS]} : result;

  // Next state selection.
  always_comb begin
    nxt_work    = work_ff;
    nxt_flags   = flags_ff;
    nxt_wr      = '0;
    nxt_pre_clr = 1'b0;
    if (op != OP_NONE) begin
      nxt_flags = new_flags;
      if (to_file) begin
        nxt_wr.we   = 1'b1;
        nxt_wr.addr = addr;
        nxt_wr.data = wr_data;
        nxt_pre_clr = (addr == TIMER_ADDR) && PRESCALER_TO_TIMER_I;
      end else begin
        nxt_work = result;
      end
    end
  end

  // State registers.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      work_ff    <= WORK_RESET;
      flags_ff   <= FLAGS_RESET;
      wr_ff      <= '0;
      pre_clr_ff <= 1'b0;
    end else begin
      work_ff    <= nxt_work;
      flags_ff   <= nxt_flags;
      wr_ff      <= nxt_wr;
      pre_clr_ff <= nxt_pre_clr;
    end
  end

  assign WORK_O          = work_ff;
  assign FILE_WR_O       = wr_ff;
  assign PRESCALER_CLR_O = pre_clr_ff;
  assign CARRY_O         = flags_ff[CARRY_POS];
  assign DIGIT_CARRY_O   = flags_ff[DIGIT_POS];
  assign ZERO_O          = flags_ff[ZERO_POS];

  // Checks next to the datapath. Each looks at the outputs one edge after the
  // instruction is taken, since every result leaves through a flip-flop.
  sequence s_addl;
    INSN_VALID_I && op == OP_ADDL;
  endsequence
  sequence s_addf_work;
    op == OP_ADDF && !dir && !FILE_IS_PORT_I;
  endsequence
  sequence s_addf_file;
    op == OP_ADDF && dir && !FILE_IS_PORT_I && addr != STATUS_ADDR;
  endsequence
  sequence s_andf_work;
    op == OP_ANDF && !dir && !FILE_IS_PORT_I;
  endsequence
  sequence s_port_andf;
    op == OP_ANDF && !dir && FILE_IS_PORT_I;
  endsequence
  sequence s_status_write;
    to_file && addr == STATUS_ADDR;
  endsequence
  sequence s_timer_write;
    to_file && addr == TIMER_ADDR && PRESCALER_TO_TIMER_I;
  endsequence
  a_addl_work_sum: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_addl |=> WORK_O == $past(work_ff + literal))
    else $error("Add literal result wrong.");
  a_andl_carry_kept: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op == OP_ANDL |=> WORK_O == $past(work_ff & literal) && $stable(CARRY_O))
    else $error("And literal changed carry or result wrong.");
  a_addf_carry_out: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op == OP_ADDF |=> CARRY_O == $past(sum_c) && DIGIT_CARRY_O == $past(sum_dig))
    else $error("Add file flags wrong.");
  a_dir_to_file: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    is_file && dir |=> FILE_WR_O.we && $stable(WORK_O))
    else $error("Direction set did not write file.");
  a_dir_to_work: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    is_file && !dir |=> !FILE_WR_O.we)
    else $error("Direction clear wrote file.");
  a_andf_digit_kept: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op == OP_ANDF |=> $stable(DIGIT_CARRY_O))
    else $error("And file changed digit carry.");
  a_status_flags_win: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    to_file && addr == STATUS_ADDR |=> FILE_WR_O.data[ZERO_POS] == ZERO_O)
    else $error("Status write lost zero flag.");
  a_port_pins_used: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_port_andf |=> WORK_O == $past(work_ff & PIN_LEVELS_I))
    else $error("Port operand not from pins.");
  a_prescaler_clear: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_timer_write |=> PRESCALER_CLR_O)
    else $error("Prescaler not cleared.");
  a_zero_flag: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op != OP_NONE |=> ZERO_O == ($past(result) == 8'h00))
    else $error("Zero flag wrong.");
  // Arithmetic checks rebuilt from the raw operands rather than the adder's own nets,
  // so a broken adder cannot hide behind its own outputs.
  a_addl_carry_out: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_addl |=> {CARRY_O, WORK_O} == $past({1'b0, work_ff} + {1'b0, literal}))
    else $error("Add literal carry wrong.");
  a_addl_digit_out: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_addl |=> DIGIT_CARRY_O ==
    $past({1'b0, work_ff[3:0]} + {1'b0, literal[3:0]} > {1'b0, LOW_NIB_MASK[3:0]}))
    else $error("Add literal digit carry wrong.");
  a_andl_digit_kept: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op == OP_ANDL |=> $stable(DIGIT_CARRY_O) && !FILE_WR_O.we)
    else $error("And literal changed digit carry or wrote file.");
  a_addf_work_sum: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_addf_work |=> WORK_O == 8'($past(work_ff) + $past(FILE_RDATA_I)))
    else $error("Add file result to work wrong.");
  a_addf_file_sum: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_addf_file |=> FILE_WR_O.data == 8'($past(work_ff) + $past(FILE_RDATA_I)))
    else $error("Add file result to register wrong.");
  a_write_addr: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    to_file |=> FILE_WR_O.addr == $past(addr))
    else $error("Write-back address wrong.");
  a_idle_state_kept: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    op == OP_NONE |=> !FILE_WR_O.we && $stable(WORK_O) && $stable(ZERO_O))
    else $error("Refused instruction changed state.");
  a_andf_work_and: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_andf_work |=> WORK_O == $past(work_ff & FILE_RDATA_I) && $stable(CARRY_O))
    else $error("And file result or carry wrong.");
  a_status_carry_win: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_status_write |=> FILE_WR_O.data[CARRY_POS] == CARRY_O &&
    FILE_WR_O.data[DIGIT_POS] == DIGIT_CARRY_O)
    else $error("Status write lost carry flags.");
  a_prescaler_idle: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    !(to_file && addr == TIMER_ADDR && PRESCALER_TO_TIMER_I) |=> !PRESCALER_CLR_O)
    else $error("Prescaler cleared without a timer write.");
endmodule : alfo_alu
`default_nettype wire

// ===== testbench/alfo_file_model.sv
// Behavioural file register space that sits beside the datapath.
`timescale 1ns/1ns
`default_nettype none
module alfo_file_model #(
  parameter logic [6:0] PORT_ADDR = 7'h06
) (
  input  wire logic                       clk_i,
  input  wire logic [6:0]                 addr_i,
  input  wire alfo_pkg::alfo_file_wr_type wr_i,
  output logic      [7:0]                 rdata_o,
  output logic                            is_port_o
);
  logic [7:0] mem [128];
  // Reads follow the address at once, since the datapath uses them in the same cycle.
  assign rdata_o   = mem[addr_i];
  assign is_port_o = (addr_i == PORT_ADDR);
  // A write-back lands on the one edge where its pulse is seen.
  always @(posedge clk_i) begin
    if (wr_i.we === 1'b1) begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end
endmodule : alfo_file_model
`default_nettype wire

// ===== testbench/alfo_alu_bench.sv
// Self-checking bench for the literal and file arithmetic datapath.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module alfo_alu_bench;
  logic clk = 1'b0, arst_n = 1'b0, valid = 1'b0, presc = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0] pins = 8'h00, rdata, work;
  logic [6:0] addr;
  logic is_port, pclr, c, dig, z;
  alfo_pkg::alfo_file_wr_type wr;
  int fails = 0, n_tests = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  alfo_alu uut (.CLK_I(clk), .ARST_N_I(arst_n), .INSN_VALID_I(valid), .INSN_I(insn),
    .FILE_RDATA_I(rdata), .FILE_IS_PORT_I(is_port), .PIN_LEVELS_I(pins),
    .PRESCALER_TO_TIMER_I(presc), .FILE_ADDR_O(addr), .FILE_WR_O(wr),
    .PRESCALER_CLR_O(pclr), .WORK_O(work), .CARRY_O(c), .DIGIT_CARRY_O(dig), .ZERO_O(z));
  alfo_file_model m (.clk_i(clk), .addr_i(addr), .wr_i(wr), .rdata_o(rdata),
    .is_port_o(is_port));
  // One instruction per call; results are settled at the closing falling edge.
  task automatic run(input logic [13:0] w);
    @(negedge clk);
    valid = 1'b1;
    insn  = w;
    @(negedge clk);
    valid = 1'b0;
  endtask : run
  task automatic set_w(input logic [7:0] v);
    run({6'h39, 8'h00});
    run({6'h3e, v});
  endtask : set_w
  task automatic chk(input logic [7:0] w_e, input logic [2:0] f_e);
    `CHK("work", w_e, work)
    `CHK("flags", f_e, {z, dig, c})
  endtask : chk
  task automatic t_lit;
    chk(8'h00, 3'b000);
    set_w(8'h10);
    run({6'h3e, 8'h15});
    chk(8'h25, 3'b000);
    run({6'h3f, 8'hdb});
    chk(8'h00, 3'b111);
    set_w(8'h08);
    run({6'h3e, 8'h08});
    chk(8'h10, 3'b010);
    set_w(8'h80);
    run({6'h3f, 8'h81});
    chk(8'h01, 3'b001);
    run({6'h39, 8'h5f});
    chk(8'h01, 3'b001);
    run({6'h39, 8'h02});
    chk(8'h00, 3'b101);
    $display("test literal done");
  endtask : t_lit
  task automatic t_file;
    set_w(8'h17);
    m.mem[7'h20] = 8'hc2;
    m.mem[7'h21] = 8'h3d;
    m.mem[7'h22] = 8'h26;
    run({6'h07, 1'b0, 7'h20});
    chk(8'hd9, 3'b000);
    `CHK("we", 1'b0, wr.we)
    run({6'h07, 1'b1, 7'h21});
    chk(8'hd9, 3'b011);
    `CHK("wr", {1'b1, 7'h21, 8'h16}, wr)
    `CHK("addr", 7'h21, addr)
    run({6'h05, 1'b1, 7'h22});
    chk(8'hd9, 3'b111);
    `CHK("wr", {1'b1, 7'h22, 8'h00}, wr)
    `CHK("mem", 8'h16, m.mem[7'h21])
    set_w(8'hff);
    m.mem[7'h06] = 8'h00;
    pins = 8'h5a;
    run({6'h05, 1'b0, 7'h06});
    chk(8'h5a, 3'b000);
    set_w(8'h02);
    m.mem[7'h03] = 8'hfe;
    run({6'h07, 1'b1, 7'h03});
    `CHK("wr", {1'b1, 7'h03, 8'h07}, wr)
    $display("test file done");
  endtask : t_file
  task automatic t_timer;
    // The timer register must hold a known value, or the flags would turn unknown.
    m.mem[7'h01] = 8'h10;
    presc = 1'b1;
    run({6'h07, 1'b1, 7'h01});
    `CHK("pclr", 1'b1, pclr)
    @(negedge clk);
    `CHK("pclr", 1'b0, pclr)
    run({6'h05, 1'b0, 7'h01});
    `CHK("pclr", 1'b0, pclr)
    presc = 1'b0;
    run({6'h07, 1'b1, 7'h01});
    `CHK("pclr", 1'b0, pclr)
    $display("test timer done");
  endtask : t_timer
  task automatic t_seq;
    set_w(8'h40);
    run({6'h38, 8'h55});
    chk(8'h40, 3'b000);
    `CHK("we", 1'b0, wr.we)
    @(negedge clk);
    insn = {6'h3e, 8'h01};
    @(negedge clk);
    `CHK("work", 8'h40, work)
    valid = 1'b1;
    @(negedge clk);
    insn = {6'h3e, 8'h02};
    @(negedge clk);
    valid = 1'b0;
    `CHK("work", 8'h43, work)
    $display("test sequence done");
  endtask : t_seq
  // Reset in mid-run, while a write-back and a prescaler pulse stand.
  task automatic t_reset;
    presc = 1'b1;
    run({6'h07, 1'b1, 7'h01});
    arst_n = 1'b0;
    #1;
    chk(8'h00, 3'b000);
    `CHK("we", 1'b0, wr.we)
    `CHK("pclr", 1'b0, pclr)
    @(negedge clk);
    arst_n = 1'b1;
    presc  = 1'b0;
    run({6'h3e, 8'h05});
    chk(8'h05, 3'b000);
    $display("test reset done");
  endtask : t_reset
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence: hold reset for four cycles, then run each scenario.
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_lit();
    t_file();
    t_timer();
    t_seq();
    t_reset();
    end_sim();
  end
  // The scenarios need well under a thousand cycles, so this cuts a hang short.
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule : alfo_alu_bench
`default_nettype wire
